// ==== hw/fsp_pkg.sv ====
// Package with register map, reset values, timing constants and carrier types.
package fsp_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_MODE      = 8'h04;
    localparam logic [7:0] ADDR_GAIN_CFG  = 8'h08;
    localparam logic [7:0] ADDR_INTEG     = 8'h0c;
    localparam logic [7:0] ADDR_INTEG_ALT = 8'h10;
    localparam logic [7:0] ADDR_GAIN      = 8'h14;
    localparam logic [7:0] ADDR_LINE_LEN  = 8'h18;
    localparam logic [7:0] ADDR_XSTART    = 8'h1c;
    localparam logic [7:0] ADDR_PLL_DIV   = 8'h20;
    localparam logic [7:0] ADDR_LIVE_INT  = 8'h24;
    localparam logic [7:0] ADDR_LIVE_GAIN = 8'h28;
    localparam logic [7:0] ADDR_STATUS    = 8'h2c;

    // Field positions in the control, mode and gain configuration registers.
    localparam int CTRL_HOLD_BIT   = 15;
    localparam int CTRL_MASK_BIT   = 9;
    localparam int CTRL_STREAM_BIT = 2;
    localparam int MODE_STREAM_BIT = 0;
    localparam int GCFG_NODLY_BIT  = 0;

    // Values after reset.
    localparam logic [15:0] RST_INTEG    = 16'h0010;
    localparam logic [15:0] RST_GAIN     = 16'h0080;
    localparam logic [15:0] RST_LINE_LEN = 16'h0e00;
    localparam logic [15:0] RST_XSTART   = 16'h0000;
    localparam logic [15:0] RST_PLL_DIV  = 16'h0001;
    localparam logic        RST_MASK     = 1'b1;

    // PLL lock wait before streaming, in microseconds, at the system clock rate.
    localparam int PLL_LOCK_US    = 1000;
    localparam int CLK_MHZ        = 40;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;

    // Live settings that steer the sensor core.
    typedef struct packed {
        logic [15:0] integ;
        logic [15:0] gain;
        logic [15:0] line_len;
        logic [15:0] xstart;
    } fsp_live_t;

    // Complete state of the block.
    typedef struct packed {
        logic        hold;
        logic        mask_en;
        logic        stream;
        logic        gain_nodly;
        fsp_live_t   pend;
        fsp_live_t   live;
        logic [3:0]  dirty;
        logic [15:0] gain_stage;
        logic        gain_staged;
        logic        bad_frame;
        logic [15:0] pll_div;
        logic [15:0] lock_cnt;
        logic        locked;
        logic [31:0] prdata;
        logic        unmapped;
    } fsp_state_t;

endpackage : fsp_pkg

// ==== hw/fsp_frame_sync.sv ====
// Frame-synchronised parameter update block with APB register access.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps

module fsp_frame_sync #(
    parameter int LOCK_CYCLES = fsp_pkg::PLL_LOCK_CYCLES
) (
    // Clock and reset.
    input  wire logic              i_clk_sys,
    input  wire logic              i_arst_n,
    // APB slave.
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Sensor timing from the readout core.
    input  wire logic              i_frame_start,
    input  wire logic              i_frame_valid_raw,
    input  wire logic              i_line_valid_raw,
    // Masked video qualifiers.
    output logic                   o_frame_valid,
    output logic                   o_line_valid,
    // Live settings and core control.
    output fsp_pkg::fsp_live_t     o_live,
    output logic      [15:0]       o_pll_div,
    output logic                   o_core_run,
    output logic                   o_bad_frame
);

    fsp_pkg::fsp_state_t st_r;
    fsp_pkg::fsp_state_t st_nxt;

    // Register map, one 32-bit word per register, values in bits 15:0.
    // 0x00 control: bit 15 holds transfers, bit 9 masks bad frames, bit 2 streams.
    // 0x04 mode: bit 0 is the same streaming bit as control bit 2.
    // 0x08 gain configuration: bit 0 removes the extra gain delay.
    // 0x0c integration time, pending copy; 0x10 reaches the same register.
    // 0x14 gain, pending copy.
    // 0x18 row period, pending copy; a change spoils the next frame.
    // 0x1c horizontal start offset, pending copy; a change spoils the next frame.
    // 0x20 PLL divisor, writable only in standby.
    // 0x24 live integration time, read only.
    // 0x28 live gain, read only.
    // 0x2c status, read only.
    //      Bit 0 is set while an integration time waits for a frame start.
    //      Bit 1 is set while a gain waits for a frame start.
    //      Bit 2 is set while a row period waits for a frame start.
    //      Bit 3 is set while a start offset waits for a frame start.
    //      Bit 4 is set while a gain is held back for one extra frame.
    //      Bit 5 is set for a frame that the last transfer spoiled.
    //      Bit 6 is set once the PLL lock wait has run out.
    // Writes to read-only registers are dropped without an error.
    // Any other address answers with an error, reads zero and drops writes.

    // Bus timing.
    // The setup cycle registers the read word and whether the address maps.
    // The access phase always completes at once, so there are no wait states.
    // A write takes effect at the edge that ends its access phase.
    // Read data stay on the bus until the next setup cycle.

    // Frame timing.
    // Every integration time, gain, row period or offset write marks that setting dirty.
    // At a frame start with hold clear, every dirty value except a staged gain moves to its live copy at once.
    // A frame start with hold set moves nothing, so held writes pile up and only the
    // last value of each setting goes live at the first frame start after hold is released.
    // A write that meets a transfer in the same cycle stays pending for the next start.
    // An integration time written during frame n goes live at the start of frame n + 1,
    // and frame n + 2 is the first one read out with it.
    // When gain and integration time go live at one start, the gain waits in a stage
    // register for one more start unless the gain configuration bit removes the delay.
    // A host must not write a new gain while a staged gain waits.
    // A row period or offset change marks the frame read at that start as bad; with
    // masking on, both qualifiers stay low for that frame, which stretches blanking.
    // The bad mark clears at the next frame start.

    // Standby and lock.
    // Clearing the streaming bit stops the core and restarts the lock wait; the bus
    // keeps answering in standby.
    // The core runs only after LOCK_CYCLES clocks of streaming, which gives the PLL
    // time to lock after new divisors.

    // Reset.
    // Reset loads the default into both the pending and the live copy of every
    // setting, clears hold and streaming, and leaves masking on.
    // The reset values are arbitrary defaults of this block.

    // Qualifier masking.
    // The frame and line qualifiers pass straight through in a good frame, so they
    // carry no extra latency; only a bad frame with masking on forces them low.

    // Limitations.
    // The lock counter is 16 bits wide, so LOCK_CYCLES must not exceed 65536.
    // A divisor write while streaming is dropped silently rather than flagged.
    // A gain written while a staged gain waits replaces it at the next start.

    logic        setup;
    logic        access;
    logic        wr_en;
    logic        take;
    logic        int_go;
    logic        gain_go;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign setup  = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign wr_en  = access && i_pwrite && !st_r.unmapped;
    assign take   = i_frame_start && !st_r.hold;

    // Values are kept right-aligned so the most significant byte of each
    // 16-bit register sits in bits 15:8, the lower byte address.
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (i_paddr)
            fsp_pkg::ADDR_CTRL: begin
                rd_word[fsp_pkg::CTRL_HOLD_BIT]   = st_r.hold;
                rd_word[fsp_pkg::CTRL_MASK_BIT]   = st_r.mask_en;
                rd_word[fsp_pkg::CTRL_STREAM_BIT] = st_r.stream;
            end
            fsp_pkg::ADDR_MODE:      rd_word[fsp_pkg::MODE_STREAM_BIT] = st_r.stream;
            fsp_pkg::ADDR_GAIN_CFG:  rd_word[fsp_pkg::GCFG_NODLY_BIT] = st_r.gain_nodly;
            fsp_pkg::ADDR_INTEG,
            fsp_pkg::ADDR_INTEG_ALT: rd_word[15:0] = st_r.pend.integ;
            fsp_pkg::ADDR_GAIN:      rd_word[15:0] = st_r.pend.gain;
            fsp_pkg::ADDR_LINE_LEN:  rd_word[15:0] = st_r.pend.line_len;
            fsp_pkg::ADDR_XSTART:    rd_word[15:0] = st_r.pend.xstart;
            fsp_pkg::ADDR_PLL_DIV:   rd_word[15:0] = st_r.pll_div;
            fsp_pkg::ADDR_LIVE_INT:  rd_word[15:0] = st_r.live.integ;
            fsp_pkg::ADDR_LIVE_GAIN: rd_word[15:0] = st_r.live.gain;
            fsp_pkg::ADDR_STATUS: begin
                rd_word[3:0] = st_r.dirty;
                rd_word[4]   = st_r.gain_staged;
                rd_word[5]   = st_r.bad_frame;
                rd_word[6]   = st_r.locked;
            end
            default:                 rd_hit = 1'b0;
        endcase
    end

    // Integration goes live together with its dirty flag; a gain that changed
    // together with integration waits one more frame start unless bypassed.
    assign int_go  = take && st_r.dirty[0];
    assign gain_go = take && st_r.dirty[1];

    always_comb begin
        st_nxt = st_r;

        // Bus setup phase: address decode is latched in the setup cycle.
        if (setup) begin
            st_nxt.prdata   = rd_word;
            st_nxt.unmapped = !rd_hit;
        end

        // Frame start transfers.
        if (take) begin
            if (st_r.dirty[0]) begin
                st_nxt.live.integ = st_r.pend.integ;
            end
            if (st_r.gain_staged) begin
                st_nxt.live.gain   = st_r.gain_stage;
                st_nxt.gain_staged = 1'b0;
            end
            if (gain_go) begin
                if (int_go && !st_r.gain_nodly) begin
                    st_nxt.gain_stage  = st_r.pend.gain;
                    st_nxt.gain_staged = 1'b1;
                end else begin
                    st_nxt.live.gain = st_r.pend.gain;
                end
            end
            if (st_r.dirty[2]) begin
                st_nxt.live.line_len = st_r.pend.line_len;
            end
            if (st_r.dirty[3]) begin
                st_nxt.live.xstart = st_r.pend.xstart;
            end
            // A row period or offset change spoils the frame read at this start.
            st_nxt.bad_frame = st_r.dirty[2] || st_r.dirty[3];
            st_nxt.dirty     = 4'h0;
        end else if (i_frame_start) begin
            st_nxt.bad_frame = 1'b0;
        end

        // Register writes; a write in the same cycle as a transfer stays dirty.
        if (wr_en) begin
            case (i_paddr)
                fsp_pkg::ADDR_CTRL: begin
                    st_nxt.hold    = i_pwdata[fsp_pkg::CTRL_HOLD_BIT];
                    st_nxt.mask_en = i_pwdata[fsp_pkg::CTRL_MASK_BIT];
                    st_nxt.stream  = i_pwdata[fsp_pkg::CTRL_STREAM_BIT];
                end
                fsp_pkg::ADDR_MODE: begin
                    st_nxt.stream = i_pwdata[fsp_pkg::MODE_STREAM_BIT];
                end
                fsp_pkg::ADDR_GAIN_CFG: begin
                    st_nxt.gain_nodly = i_pwdata[fsp_pkg::GCFG_NODLY_BIT];
                end
                fsp_pkg::ADDR_INTEG,
                fsp_pkg::ADDR_INTEG_ALT: begin
                    st_nxt.pend.integ = i_pwdata[15:0];
                    st_nxt.dirty[0]   = 1'b1;
                end
                fsp_pkg::ADDR_GAIN: begin
                    st_nxt.pend.gain = i_pwdata[15:0];
                    st_nxt.dirty[1]  = 1'b1;
                end
                fsp_pkg::ADDR_LINE_LEN: begin
                    st_nxt.pend.line_len = i_pwdata[15:0];
                    st_nxt.dirty[2]      = 1'b1;
                end
                fsp_pkg::ADDR_XSTART: begin
                    st_nxt.pend.xstart = i_pwdata[15:0];
                    st_nxt.dirty[3]    = 1'b1;
                end
                fsp_pkg::ADDR_PLL_DIV: begin
                    // Divisors are only accepted in standby.
                    if (!st_r.stream) begin
                        st_nxt.pll_div = i_pwdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Lock wait: the core starts only after the PLL has had time to lock.
        if (!st_r.stream) begin
            st_nxt.lock_cnt = 16'h0000;
            st_nxt.locked   = 1'b0;
        end else if (!st_r.locked) begin
            if (st_r.lock_cnt == 16'(LOCK_CYCLES - 1)) begin
                st_nxt.locked = 1'b1;
            end else begin
                st_nxt.lock_cnt = st_r.lock_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r               <= '0;
            st_r.mask_en       <= fsp_pkg::RST_MASK;
            st_r.pend.integ    <= fsp_pkg::RST_INTEG;
            st_r.pend.gain     <= fsp_pkg::RST_GAIN;
            st_r.pend.line_len <= fsp_pkg::RST_LINE_LEN;
            st_r.pend.xstart   <= fsp_pkg::RST_XSTART;
            st_r.live.integ    <= fsp_pkg::RST_INTEG;
            st_r.live.gain     <= fsp_pkg::RST_GAIN;
            st_r.live.line_len <= fsp_pkg::RST_LINE_LEN;
            st_r.live.xstart   <= fsp_pkg::RST_XSTART;
            st_r.gain_stage    <= fsp_pkg::RST_GAIN;
            st_r.pll_div       <= fsp_pkg::RST_PLL_DIV;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus answers: one wait-free access phase after the registered setup.
    assign o_prdata  = st_r.prdata;
    assign o_pready  = access;
    assign o_pslverr = access && st_r.unmapped;

    // Bad frames are blanked while masking is on, so vertical blanking grows by one frame.
    assign o_frame_valid = i_frame_valid_raw && !(st_r.bad_frame && st_r.mask_en);
    assign o_line_valid  = i_line_valid_raw && !(st_r.bad_frame && st_r.mask_en);

    assign o_live      = st_r.live;
    assign o_pll_div   = st_r.pll_div;
    assign o_core_run  = st_r.stream && st_r.locked;
    assign o_bad_frame = st_r.bad_frame;

endmodule : fsp_frame_sync

// ==== testbench/fsp_checker.sv ====
// Concurrent checks on the ports of the frame-synchronised parameter block.
`timescale 1ns/1ps
module fsp_checker #(
    parameter int LOCK_CYCLES = 8
) (
    // Clock, reset, bus and frame timing.
    input wire logic               i_clk_sys,
    input wire logic               i_arst_n,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [7:0]         i_paddr,
    input wire logic               i_frame_start,
    input wire logic               i_frame_valid_raw,
    input wire logic               i_line_valid_raw,
    // Watched outputs.
    input wire logic               o_pready,
    input wire logic               o_frame_valid,
    input wire logic               o_line_valid,
    input wire fsp_pkg::fsp_live_t o_live,
    input wire logic               o_core_run,
    input wire logic               o_bad_frame
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // Cycles since the last write that could have changed the streaming bit.
    int since_mode_wr;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since_mode_wr <= 0;
        end else if (i_psel && i_penable && i_pwrite && (i_paddr == fsp_pkg::ADDR_CTRL ||
                     i_paddr == fsp_pkg::ADDR_MODE)) begin
            since_mode_wr <= 0;
        end else if (since_mode_wr < LOCK_CYCLES) begin
            since_mode_wr <= since_mode_wr + 1;
        end
    end
    AST_LIVE_SYNC: assert property (
        !$past(i_frame_start) |-> $stable(o_live)) else $error("live moved off frame start");
    AST_RESET_LIVE: assert property (
        $rose(i_arst_n) |-> o_live == {fsp_pkg::RST_INTEG, fsp_pkg::RST_GAIN,
        fsp_pkg::RST_LINE_LEN, fsp_pkg::RST_XSTART} && !o_bad_frame) else $error("bad reset");
    AST_BAD_RISE: assert property (
        $rose(o_bad_frame) |-> $past(i_frame_start)) else $error("bad frame began off start");
    AST_BAD_FALL: assert property (
        $fell(o_bad_frame) |-> $past(i_frame_start)) else $error("bad frame ended off start");
    AST_CLEAN_PASS: assert property (
        !o_bad_frame |-> o_frame_valid == i_frame_valid_raw && o_line_valid == i_line_valid_raw)
        else $error("valid gated in good frame");
    AST_MASK_BOTH: assert property (
        o_bad_frame && i_line_valid_raw |-> o_frame_valid == o_line_valid)
        else $error("valids masked unequally");
    AST_APB_READY: assert property (
        o_pready == (i_psel && i_penable)) else $error("ready outside access phase");
    AST_LOCK_WAIT: assert property (
        $rose(o_core_run) |-> since_mode_wr >= LOCK_CYCLES) else $error("ran before lock");
endmodule : fsp_checker

// ==== testbench/fsp_core_model.sv ====
// Readout core model that paces frames while the core runs.
`timescale 1ns/1ps
module fsp_core_model (
    // Clock, reset and run request.
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    input  wire logic i_run,
    // Unmasked frame timing.
    output logic      o_frame_start,
    output logic      o_frame_valid_raw,
    output logic      o_line_valid_raw
);
    logic [5:0] cnt_r;

    // A started frame always completes, so stopping never leaves a torn frame.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) cnt_r <= 6'h00;
        else if (i_run || cnt_r != 6'h00) cnt_r <= cnt_r + 6'h01;
    end
    assign o_frame_start     = cnt_r == 6'h01;
    assign o_frame_valid_raw = cnt_r >= 6'h08 && cnt_r < 6'h38;
    assign o_line_valid_raw  = o_frame_valid_raw && cnt_r[1];
endmodule : fsp_core_model

// ==== testbench/fsp_frame_sync_tb.sv ====
// Self-checking bench for the frame-synchronised parameter block.
`timescale 1ns/1ps
module fsp_frame_sync_tb;
    localparam int LOCK = 8;
    logic               clk, arst_n, psel, penable, pwrite, fs, fvr, lvr;
    logic               pready, pslverr, fv, lv, run, bad, rd_e, nodly, stg, mbad;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd_d;
    logic [15:0]        pll, mctl;
    logic [3:0]         dirty;
    fsp_pkg::fsp_live_t live_o;
    int                 n_errors = 0, n_checks = 0, cyc = 0, stg_v, pend[4], mlive[4];

    fsp_frame_sync #(.LOCK_CYCLES(LOCK)) fsp_frame_sync_inst (.i_clk_sys(clk),
        .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_frame_start(fs), .i_frame_valid_raw(fvr),
        .i_line_valid_raw(lvr), .o_frame_valid(fv), .o_line_valid(lv), .o_live(live_o),
        .o_pll_div(pll), .o_core_run(run), .o_bad_frame(bad));
    fsp_core_model fsp_core_model_inst (.i_clk_sys(clk), .i_arst_n(arst_n), .i_run(run),
        .o_frame_start(fs), .o_frame_valid_raw(fvr), .o_line_valid_raw(lvr));

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'h1 && t < 20);
        chk("pready", pready, 1'h1);
        rd_d = prdata;
        rd_e = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int i;
        i = -1;
        apb(1'h1, a, {16'h0000, d});
        case (a)
            fsp_pkg::ADDR_CTRL: mctl = d & 16'h8204;
            fsp_pkg::ADDR_MODE: mctl[2] = d[0];
            fsp_pkg::ADDR_GAIN_CFG: nodly = d[0];
            fsp_pkg::ADDR_INTEG, fsp_pkg::ADDR_INTEG_ALT: i = 0;
            fsp_pkg::ADDR_GAIN: i = 1;
            fsp_pkg::ADDR_LINE_LEN: i = 2;
            fsp_pkg::ADDR_XSTART: i = 3;
            default: ;
        endcase
        if (i >= 0) pend[i] = d;
        if (i >= 0) dirty[i] = 1'h1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        apb(1'h0, a, 32'h0);
        chk("prdata", rd_d, {16'h0000, e});
    endtask : rd

    task automatic cmp();
        chk("live", live_o, {16'(mlive[0]), 16'(mlive[1]), 16'(mlive[2]), 16'(mlive[3])});
        chk("bad_frame", bad, mbad);
    endtask : cmp

    // Waits for a frame start, advances the model with it, then checks.
    task automatic frm();
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (fs !== 1'h1 && t < 200);
        chk("frame_start", fs, 1'h1);
        @(posedge clk);
        mbad = 1'h0;
        if (!mctl[15]) begin
            mbad = dirty[2] | dirty[3];
            if (stg) mlive[1] = stg_v;
            stg = dirty[0] & dirty[1] & !nodly;
            stg_v = pend[1];
            if (stg) dirty[1] = 1'h0;
            for (int i = 0; i < 4; i++) if (dirty[i]) mlive[i] = pend[i];
            dirty = 4'h0;
        end
        #1;
        cmp();
        repeat (12) @(negedge clk);
        chk("frame_valid", fv, fvr & !(mbad & mctl[9]));
        chk("line_valid", lv, lvr & !(mbad & mctl[9]));
    endtask : frm

    initial begin
        logic [15:0] v;
        {clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {dirty, stg, nodly, mbad, stg_v} = '0;
        mctl = 16'h0200;
        mlive = '{fsp_pkg::RST_INTEG, fsp_pkg::RST_GAIN, fsp_pkg::RST_LINE_LEN,
                  fsp_pkg::RST_XSTART};
        pend = mlive;
        void'($urandom(32'ha779));
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        cmp();
        rd(fsp_pkg::ADDR_INTEG, fsp_pkg::RST_INTEG);
        rd(fsp_pkg::ADDR_GAIN, fsp_pkg::RST_GAIN);
        rd(fsp_pkg::ADDR_CTRL, 16'h0200);
        apb(1'h0, 8'hfc, 32'h0);
        chk("unmapped", {rd_e, rd_d}, 33'h100000000);
        wr(fsp_pkg::ADDR_PLL_DIV, 16'h0005);
        rd(fsp_pkg::ADDR_PLL_DIV, 16'h0005);
        wr(fsp_pkg::ADDR_MODE, 16'h0001);
        rd(fsp_pkg::ADDR_CTRL, 16'h0204);
        repeat (4 * LOCK) if (run !== 1'h1) @(posedge clk);
        chk("core_run", run, 1'h1);
        chk("pll_div", pll, 16'h0005);
        wr(fsp_pkg::ADDR_PLL_DIV, 16'h0009);
        rd(fsp_pkg::ADDR_PLL_DIV, 16'h0005);
        frm();
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom);
            wr(fsp_pkg::ADDR_INTEG_ALT, v);
            rd(fsp_pkg::ADDR_INTEG, v);
            cmp();
            frm();
            rd(fsp_pkg::ADDR_LIVE_INT, 16'(mlive[0]));
        end
        wr(fsp_pkg::ADDR_CTRL, 16'h8204);
        wr(fsp_pkg::ADDR_GAIN, 16'($urandom));
        wr(fsp_pkg::ADDR_GAIN, v);
        wr(fsp_pkg::ADDR_XSTART, ~v);
        frm();
        rd(fsp_pkg::ADDR_STATUS, {9'h000, 1'h1, mbad, stg, dirty});
        wr(fsp_pkg::ADDR_CTRL, 16'h0204);
        frm();
        wr(fsp_pkg::ADDR_INTEG, ~v);
        wr(fsp_pkg::ADDR_GAIN, v ^ 16'h00ff);
        frm();
        rd(fsp_pkg::ADDR_LIVE_GAIN, 16'(mlive[1]));
        frm();
        wr(fsp_pkg::ADDR_GAIN_CFG, 16'h0001);
        wr(fsp_pkg::ADDR_INTEG, v);
        wr(fsp_pkg::ADDR_GAIN, ~v);
        frm();
        wr(fsp_pkg::ADDR_CTRL, 16'h0004);
        wr(fsp_pkg::ADDR_LINE_LEN, v);
        frm();
        end_sim();
    end
endmodule : fsp_frame_sync_tb

bind fsp_frame_sync fsp_checker #(.LOCK_CYCLES(LOCK_CYCLES)) fsp_checker_inst (.i_clk_sys,
    .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_frame_start, .i_frame_valid_raw,
    .i_line_valid_raw, .o_pready, .o_frame_valid, .o_line_valid, .o_live, .o_core_run,
    .o_bad_frame);
